/* hw/tcs_pkg.sv */
// Package for the transmit clock select block: register map, fields, resets.
// Assumes a 32-bit APB slave with word-aligned registers.
package tcs_pkg;

  // Register byte offsets
  localparam logic [7:0] TCS_OFF_CTRL   = 8'h00;
  localparam logic [7:0] TCS_OFF_STATUS = 8'h04;
  localparam logic [7:0] TCS_OFF_MASK   = 8'h08;
  localparam logic [7:0] TCS_OFF_STATE  = 8'h0c;

  // Control register fields
  localparam int TCS_BIT_VIOL   = 7;
  localparam int TCS_BIT_T1     = 6;
  localparam int TCS_BIT_SYNC8K = 5;
  localparam int TCS_BIT_CLKDET = 4;
  localparam int TCS_SRC_LSB    = 0;

  // Reset values
  localparam logic [7:0] TCS_CTRL_RESET = 8'h11;
  localparam logic [7:0] TCS_MASK_RESET = 8'h00;

  // Interrupt status bit for clock loss
  localparam int TCS_IRQ_CLKLOSS = 5;

  // 8 kHz frame reference from the 200 MHz clock
  localparam int TCS_CLK_HZ      = 200_000_000;
  localparam int TCS_FRAME_HZ    = 8_000;
  localparam int TCS_FRAME_TICKS = TCS_CLK_HZ / TCS_FRAME_HZ;

  // Timing source encodings
  typedef enum logic [1:0] {
    TCS_SRC_LOOP0 = 2'b00,
    TCS_SRC_EXT   = 2'b01,
    TCS_SRC_PLL   = 2'b10,
    TCS_SRC_LOOP1 = 2'b11
  } tcs_src_e;

  // Control register as a struct
  typedef struct packed {
    logic     viol_insert;
    logic     t1_mode;
    logic     sync_8k;
    logic     clk_loss_en;
    logic [1:0] reserved;
    tcs_src_e src;
  } tcs_ctrl_s;

  // Pin direction group
  typedef struct packed {
    logic serclk_oe;
    logic sync_oe;
    logic msync_oe;
  } tcs_dir_s;

endpackage : tcs_pkg

/* hw/tcs_sync2.sv */
// Two-flop synchroniser for inputs from outside the clk_sys domain.
// Assumes the input is a slow level.
`timescale 1ns/1ps
module tcs_sync2 (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  // First flop feeds only the second
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : tcs_sync2

/* hw/tcs_top.sv */
// Transmit clock select for one T1/E1 framer channel, with APB registers.
// Assumes an APB master on clk_sys and asynchronous line/pin status inputs.
// Behaviour
// [RQ1] 0-to-1 on bit 7 inserts one violation
// [RQ2] Bit 6 selects T1, clear selects E1
// [RQ3] Bit 5 aligns frames to 8 kHz
// [RQ4] Alignment only under PLL timing source
// [RQ5] Lost recovery falls back to PLL timing
// [RQ6] Bit 4 enables protection, resets to one
// [RQ7] Clock-loss status only when protection enabled
// [RQ8] Source 00/11 loop timing, clock pin output
// [RQ9] Source 01 external timing, clock pin input
// [RQ10] Source 10 PLL timing, clock pin output
// [RQ11] Base rate sync direction follows polarity select
// [RQ12] High-speed modes make all three pins inputs
// [RQ13] Insert detected by comparing with previous value
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module tcs_top #(
  parameter int FRAME_TICKS = tcs_pkg::TCS_FRAME_TICKS
) (
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                line_recovery_ok,
  input  wire logic                sync_polarity_select,
  input  wire logic                high_speed_mode,
  output tcs_pkg::tcs_src_e        tx_timing_used,
  output logic                     t1_mode,
  output logic                     frame_align_pulse,
  output logic                     line_code_violation,
  output tcs_pkg::tcs_dir_s        pin_dir,
  output logic                     irq
);
  import tcs_pkg::*;

  localparam int CW = $clog2(FRAME_TICKS);

  tcs_ctrl_s   ctrl_q;
  logic [7:0]  status_q;
  logic [7:0]  mask_q;
  logic        rec_ok;
  logic        spol;
  logic        hspeed;
  logic        rec_ok_prev_q;
  logic        fallback_q;
  logic [CW-1:0] frame_cnt_q;
  logic        wr_ctrl;
  logic        rd_status;
  logic        access;
  logic        loop_src;
  logic        clk_lost_evt;
  logic [7:0]  rdata_d;
  tcs_src_e    eff_src;

  // Pin inputs from outside the clock domain
  tcs_sync2 u_sync_rec (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (line_recovery_ok),
    .dout    (rec_ok)
  );
  tcs_sync2 u_sync_pol (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (sync_polarity_select),
    .dout    (spol)
  );
  tcs_sync2 u_sync_hs (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .din     (high_speed_mode),
    .dout    (hspeed)
  );

  // Loop timing decode, used in several places
  function automatic logic is_loop(input tcs_src_e s);
    return (s == TCS_SRC_LOOP0) || (s == TCS_SRC_LOOP1);
  endfunction : is_loop

  // APB decode, zero wait states
  assign access    = psel && penable;
  assign wr_ctrl   = access && pwrite && (paddr == TCS_OFF_CTRL);
  assign rd_status = access && !pwrite && (paddr == TCS_OFF_STATUS);
  assign loop_src  = is_loop(ctrl_q.src);

  // Control register write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= TCS_CTRL_RESET; // [RQ2] [RQ6] [RQ9]
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[7:0];
    end
  end

  // Single violation on rising edge of written bit 7
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      line_code_violation <= 1'b0;
    end else begin
      line_code_violation <= wr_ctrl && pwdata[TCS_BIT_VIOL]
                             && !ctrl_q.viol_insert; // [RQ1] [RQ13]
    end
  end

  // Mask register write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mask_q <= TCS_MASK_RESET;
    end else if (access && pwrite && (paddr == TCS_OFF_MASK)) begin
      mask_q <= pwdata[7:0];
    end
  end

  // Clock-loss fallback to PLL while recovery is lost
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fallback_q    <= 1'b0;
      rec_ok_prev_q <= 1'b0;
    end else begin
      rec_ok_prev_q <= rec_ok;
      fallback_q    <= ctrl_q.clk_loss_en && loop_src && !rec_ok; // [RQ5]
    end
  end

  // Loss event only counted with protection on
  assign clk_lost_evt = ctrl_q.clk_loss_en && loop_src
                        && rec_ok_prev_q && !rec_ok; // [RQ7]

  // Sticky status, set wins over read-clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_q <= 8'h00;
    end else begin
      if (rd_status) begin
        status_q <= 8'h00;
      end
      if (clk_lost_evt) begin
        status_q[TCS_IRQ_CLKLOSS] <= 1'b1; // [RQ7]
      end
    end
  end

  // Interrupt output
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // Effective timing source
  always_comb begin
    eff_src = ctrl_q.src;
    if (fallback_q) begin
      eff_src = TCS_SRC_PLL; // [RQ5]
    end
  end

  // Mode and source outputs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_timing_used <= TCS_SRC_EXT;
      t1_mode        <= 1'b0;
    end else begin
      tx_timing_used <= eff_src; // [RQ8] [RQ9] [RQ10]
      t1_mode        <= ctrl_q.t1_mode; // [RQ2]
    end
  end

  // Pin directions
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_dir <= '0;
    end else if (hspeed) begin
      pin_dir <= '0; // [RQ12]
    end else begin
      pin_dir.serclk_oe <= (ctrl_q.src != TCS_SRC_EXT); // [RQ8] [RQ9] [RQ10]
      pin_dir.sync_oe   <= spol; // [RQ11]
      pin_dir.msync_oe  <= spol; // [RQ11]
    end
  end

  // 8 kHz frame alignment from the clk_sys domain count
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      frame_cnt_q       <= '0;
      frame_align_pulse <= 1'b0;
    end else begin
      if (frame_cnt_q == CW'(FRAME_TICKS - 1)) begin
        frame_cnt_q <= '0;
      end else begin
        frame_cnt_q <= frame_cnt_q + 1'b1;
      end
      frame_align_pulse <= (frame_cnt_q == CW'(FRAME_TICKS - 1))
                           && ctrl_q.sync_8k // [RQ3]
                           && (eff_src == TCS_SRC_PLL); // [RQ4]
    end
  end

  // Read mux
  always_comb begin
    unique case (paddr)
      TCS_OFF_CTRL:   rdata_d = ctrl_q;
      TCS_OFF_STATUS: rdata_d = status_q;
      TCS_OFF_MASK:   rdata_d = mask_q;
      TCS_OFF_STATE:  rdata_d = {5'h00, fallback_q, rec_ok, hspeed};
      default:        rdata_d = 8'h00;
    endcase
  end

  // APB answer registered, one access cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr[1:0] != 2'b00 || paddr > TCS_OFF_STATE);
      prdata  <= {24'h00_0000, rdata_d};
    end
  end

endmodule : tcs_top

/* bench/tcs_properties.sv */
// Port checker for tcs_top, bound from the bench.
// Assumes the bench leaves an idle cycle between APB transfers.
`timescale 1ns/1ps
module tcs_properties (
  input wire logic              clk_sys,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              high_speed_mode,
  input wire logic              sync_polarity_select,
  input wire tcs_pkg::tcs_src_e tx_timing_used,
  input wire logic              t1_mode,
  input wire logic              frame_align_pulse,
  input wire logic              line_code_violation,
  input wire tcs_pkg::tcs_dir_s pin_dir,
  input wire logic              irq
);
  import tcs_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Completed control write, and one asking for a violation
  wire wr = psel && penable && pready && pwrite && paddr == TCS_OFF_CTRL;
  wire wv = wr && pwdata[7];
  hs_dir_a: assert property (high_speed_mode[*4] |-> pin_dir == 3'b000)
    else $error("pins driven in high-speed mode");
  sync_dir_a: assert property ((!high_speed_mode && $stable(sync_polarity_select))[*4] |->
    pin_dir.sync_oe == sync_polarity_select && pin_dir.msync_oe == sync_polarity_select)
    else $error("sync pin direction wrong");
  clk_dir_a: assert property ((!high_speed_mode && $stable(tx_timing_used))[*4] |->
    pin_dir.serclk_oe == (tx_timing_used != TCS_SRC_EXT)) else $error("clock pin direction wrong");
  frame_src_a: assert property (frame_align_pulse |-> tx_timing_used == TCS_SRC_PLL ||
    $past(tx_timing_used) == TCS_SRC_PLL) else $error("frame pulse without PLL timing");
  viol_cause_a: assert property (line_code_violation |-> $past(wv) || $past(wv, 2))
    else $error("violation without request");
  viol_single_a: assert property (line_code_violation |=> !line_code_violation)
    else $error("violation pulse too long");
  t1_follow_a: assert property (wr |-> ##2 t1_mode == $past(pwdata[6], 2))
    else $error("mode bit not applied");
  irq_src_a: assert property ($rose(irq) |-> tx_timing_used == TCS_SRC_PLL)
    else $error("interrupt without fallback");
  bad_addr_a: assert property (pready && (paddr > 8'h0c || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("bad address accepted");
  cover property (frame_align_pulse);
  cover property ($rose(irq));
  cover property (line_code_violation);
endmodule : tcs_properties

/* bench/tcs_far_end.sv */
// Line-side partner: recovery status and rate mode.
// Assumes commands from the bench on clk_sys.
`timescale 1ns/1ps
module tcs_far_end (
  input wire logic clk_sys,
  input wire logic lose,
  input wire logic hs,
  output logic     line_recovery_ok = 1'b1,
  output logic     high_speed_mode = 1'b0
);
  // Follow commands one cycle late
  always @(posedge clk_sys) begin
    line_recovery_ok <= !lose;
    high_speed_mode <= hs;
  end
endmodule : tcs_far_end

/* bench/tb.sv */
// Bench for tcs_top: APB tasks, queued read checks, port checks.
// Assumes tcs_far_end on the line side, FRAME_TICKS cut to 8.
`timescale 1ns/1ps
module tb;
  import tcs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, lose = 1'b0, hs = 1'b0, sync_polarity_select = 1'b0;
  logic        line_recovery_ok, high_speed_mode, t1_mode, frame_align_pulse;
  logic        line_code_violation, irq, t;
  tcs_src_e    tx_timing_used;
  tcs_dir_s    pin_dir;
  logic [31:0] q[$];
  int          fail_count = 0, checks = 0, cyc = 0, nv = 0, nf = 0, b;
  integer      seed = 32'h6c7fb793;
  always #2.5 clk_sys = ~clk_sys;
  tcs_far_end u_far (.clk_sys(clk_sys), .lose(lose), .hs(hs),
    .line_recovery_ok(line_recovery_ok), .high_speed_mode(high_speed_mode));
  tcs_top #(.FRAME_TICKS(8)) DUT (.*);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // One transfer; d is write data or the expected read data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) q.push_back(d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys iff pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  // Read monitor, pulse counters, hang limit
  always @(posedge clk_sys) begin
    cyc++;
    nv <= nv + line_code_violation;
    nf <= nf + frame_align_pulse;
    if (psel && penable && pready === 1'b1 && !pwrite) chk(prdata, q.pop_front());
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    apb(0, TCS_OFF_CTRL, 32'h11);
    apb(0, TCS_OFF_MASK, 32'h0);
    chk(tx_timing_used, TCS_SRC_EXT);
    for (int s = 0; s < 4; s++) begin
      t = 1'($random(seed));
      apb(1, TCS_OFF_CTRL, {24'h0, 1'b0, t, 4'h0, 2'(s)});
      apb(0, TCS_OFF_CTRL, {24'h0, 1'b0, t, 4'h0, 2'(s)});
      chk(tx_timing_used, s);
      chk(t1_mode, t);
      chk(pin_dir.serclk_oe, s != 1);
    end
    apb(1, TCS_OFF_CTRL, 32'h22);
    repeat (4) @(posedge clk_sys);
    b = nf;
    repeat (80) @(posedge clk_sys);
    chk(nf - b, 10);
    apb(1, TCS_OFF_CTRL, 32'h20);
    repeat (4) @(posedge clk_sys);
    b = nf;
    repeat (40) @(posedge clk_sys);
    chk(nf - b, 0);
    b = nv;
    apb(1, TCS_OFF_CTRL, 32'h81);
    apb(1, TCS_OFF_CTRL, 32'h81);
    repeat (3) @(posedge clk_sys);
    chk(nv - b, 1);
    apb(1, TCS_OFF_CTRL, 32'h01);
    apb(1, TCS_OFF_CTRL, 32'h81);
    repeat (3) @(posedge clk_sys);
    chk(nv - b, 2);
    apb(1, TCS_OFF_MASK, 32'h20);
    apb(1, TCS_OFF_CTRL, 32'h13);
    lose <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(irq, 1);
    chk(tx_timing_used, TCS_SRC_PLL);
    apb(0, TCS_OFF_STATUS, 32'h20);
    lose <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk(irq, 0);
    chk(tx_timing_used, TCS_SRC_LOOP1);
    apb(1, TCS_OFF_CTRL, 32'h03);
    lose <= 1'b1;
    repeat (10) @(posedge clk_sys);
    chk(tx_timing_used, TCS_SRC_LOOP1);
    apb(0, TCS_OFF_STATUS, 32'h0);
    apb(0, 8'h10, 32'h0);
    hs <= 1'b1;
    sync_polarity_select <= 1'($random(seed));
    repeat (6) @(posedge clk_sys);
    chk(pin_dir, 3'b000);
    hs <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(pin_dir.sync_oe, sync_polarity_select);
    chk(pin_dir.msync_oe, sync_polarity_select);
    complete_run();
  end
endmodule : tb
bind tcs_top tcs_properties u_props (.*);
